//--- bench/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "usmim_defines.vh"
module tb;
  // Drive, observe and bookkeeping
  logic clk = 0, reset_n = 0, regWrStrobe = 0, regRdStrobe = 0, txSerialOut = 1, rdLate = 0, sp = 0;
  logic [7:0] regAddr = 8'h0;
  logic [9:0] statusEvent = 10'h0;
  logic [31:0] regWrData = 32'h0, d, b, cnt, tg;
  logic [31:0] expQ[$];
  logic [7:0] rstA[5] = '{8'h04, 8'h10, 8'h14, 8'h08, 8'h20};
  wire logic [31:0] regRdData;
  wire logic irqOut, rxdPin, txdPin, sclkPinIn, sclkPinOut, sclkPinOe, baudTick, rxSerialIn, lineStable;
  integer n_errors = 0, samples_checked = 0, cyc = 0, seed = 53, i, k;
  usmim_top u_dut (.clk, .reset_n, .regAddr, .regWrData, .regWrStrobe, .regRdStrobe, .regRdData,
    .statusEvent, .irqOut, .rxdPin, .txdPin, .sclkPinIn, .sclkPinOut, .sclkPinOe, .txSerialOut,
    .rxSerialIn, .rxPathEnable(), .txPathEnable(), .baudTick, .charBits(), .syncMode(),
    .parityEnable(), .parityKind(), .multiDrop(), .stopHalfBits(), .xferChanDisable());
  usmim_serial_peer u_peer (.clk, .rxdPin, .sclkPinIn, .lineStable);
  ////////////////////////////////////////////////////////////
  task automatic chkw(logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkb(logic got, logic exp);
    chkw({31'h0, got}, {31'h0, exp});
  endtask
  // One bus cycle after the edge; a read notes its expected word
  task automatic op(logic w, logic r, logic [7:0] a, logic [31:0] v, logic [9:0] e);
    @(posedge clk);
    regWrStrobe <= w;
    regRdStrobe <= r;
    regAddr <= a;
    regWrData <= v;
    statusEvent <= e;
    if (r)
      expQ.push_back(v);
  endtask
  task automatic idle(int c);
    repeat (c) op(0, 0, 8'h00, 32'h0, 10'h0);
  endtask
  task automatic final_report();
    if (n_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Clock
  initial
  begin
    forever #5 clk = ~clk;
  end
  // Read data checked in the slot after each read strobe
  always @(posedge clk)
    rdLate <= regRdStrobe;
  always @(negedge clk)
    if (rdLate === 1'b1)
      chkw(regRdData, expQ.pop_front());
  // Hang guard, far above the expected run length
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_errors++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    idle(2);
    foreach (rstA[j]) op(0, 1, rstA[j], 32'h0, 0);
    op(1, 0, 8'h10, 32'h3FF, 0);
    op(0, 1, 8'h10, 32'h0, 0);
    idle(2);
    @(negedge clk) chkb(txdPin, 1'b1);
    chkb(irqOut, 1'b0);
    // Random configurations read back through the writable mask
    for (k = 0; k < 12; k++)
    begin
      d = $random(seed);
      d[12] = d[12] & ~d[13] & ~d[8];
      op(1, 0, 8'h04, d, 0);
      op(0, 1, 8'h04, d & `USMIM_MODE_WMASK, 0);
    end
    // Baud tick rate and clock pin drive per source
    for (k = 0; k < 3; k++)
    begin
      op(1, 0, 8'h04, (k << 4) | 32'h40000, 0);
      idle(4);
      cnt = 0;
      tg = 0;
      // Driven clock pin toggles once per tick, stays low when undriven
      @(negedge clk) sp = sclkPinOut;
      repeat (64)
      begin
        @(negedge clk);
        cnt += baudTick;
        tg += (sclkPinOut !== sp);
        sp = sclkPinOut;
      end
      chkw(cnt, k ? 32'h8 : 32'h40);
      chkw(tg, k == 0 ? 32'h40 : k == 1 ? 32'h8 : 32'h0);
      chkb(sclkPinOe, k < 2);
    end
    // Pin routing in each channel mode
    for (k = 0; k < 4; k++)
    begin
      op(1, 0, 8'h04, k << 14, 0);
      txSerialOut <= k[0];
      idle(8);
      repeat (48)
      begin
        @(negedge clk);
        if (lineStable)
        begin
          chkb(txdPin, k == 2 ? 1'b1 : k == 0 ? txSerialOut : rxdPin);
          chkb(rxSerialIn, k == 3 ? 1'b1 : k == 2 ? txSerialOut : rxdPin);
        end
      end
    end
    // Each source enabled, raised, cleared, then masked
    for (i = 0; i < 10; i++)
    begin
      b = 32'h1 << i;
      op(1, 0, 8'h08, b, 0);
      op(1, 0, 8'h0C, 32'h0, 0);
      op(1, 0, 8'h08, 32'h0, 0);
      op(0, 1, 8'h10, b, 0);
      op(0, 0, 8'h00, 32'h0, b[9:0]);
      idle(1);
      @(negedge clk) chkb(irqOut, 1'b1);
      op(0, 1, 8'h14, b, 0);
      idle(2);
      @(negedge clk) chkb(irqOut, 1'b0);
      op(1, 0, 8'h0C, b, 0);
      op(0, 1, 8'h10, 32'h0, 0);
      op(0, 0, 8'h00, 32'h0, b[9:0]);
      idle(1);
      @(negedge clk) chkb(irqOut, 1'b0);
      op(0, 1, 8'h14, b, 0);
    end
    op(1, 0, 8'h0C, 32'h3FF, 0);
    idle(3);
    final_report();
  end
endmodule // tb
`default_nettype wire

//--- bench/usmim_serial_peer.sv
`timescale 1ns/1ns
`default_nettype none
module usmim_serial_peer (
  // Clock
  input wire logic clk,
  // Lines towards the channel
  output logic rxdPin,
  output logic sclkPinIn,
  output logic lineStable
);
  logic [3:0] phase = 4'h0;
  // Idle-high line at start
  initial
    rxdPin = 1'b1;
  // Sixteen cycles per bit, so a level stands long enough to cross the synchroniser
  always @(posedge clk)
  begin
    phase <= phase + 4'h1;
    if (phase == 4'hF)
      rxdPin <= ~rxdPin;
  end
  // Serial clock of eight cycles; second half of each bit is settled
  assign sclkPinIn = phase[2];
  assign lineStable = phase[3];
endmodule // usmim_serial_peer
`default_nettype wire

//--- bench/usmim_top_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module usmim_top_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  input wire logic [31:0] regRdData,
  // Watched outputs
  input wire logic irqOut,
  input wire logic txdPin,
  input wire logic rxPathEnable,
  input wire logic txPathEnable,
  input wire logic sclkPinOe,
  input wire logic [3:0] charBits,
  input wire logic syncMode,
  input wire logic parityEnable,
  input wire logic [1:0] parityKind,
  input wire logic multiDrop,
  input wire logic [2:0] stopHalfBits,
  input wire logic xferChanDisable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Mode write taken at this edge
  wire modeWr = regWrStrobe && regAddr == 8'h04;
  // Stop length in half bits; reserved codes fall back to one bit
  function automatic logic [2:0] halfOf(logic [1:0] f, logic s);
    return f == 2'h2 ? 3'h4 : (f == 2'h1 && !s) ? 3'h3 : 3'h2;
  endfunction
  chk_rd_quiet: assert property (!regRdStrobe |=> regRdData == 32'h0)
    else $error("read data outside its slot");
  chk_mask_width: assert property (regRdStrobe && regAddr == 8'h10 |=> regRdData[31:10] == 22'h0)
    else $error("mask read has upper bits");
  chk_wo_read: assert property (regRdStrobe && regAddr inside {8'h08, 8'h0C} |=> regRdData == 32'h0)
    else $error("write-only place read nonzero");
  chk_irq_off: assert property (regWrStrobe && regAddr == 8'h0C && regWrData[9:0] == 10'h3FF |=> !irqOut)
    else $error("interrupt with all sources disabled");
  chk_char_len: assert property (modeWr |-> ##2 charBits ==
    ($past(regWrData[17], 2) ? 4'h9 : 4'h5 + $past(regWrData[7:6], 2)))
    else $error("character length decode");
  chk_nine_xfer: assert property (modeWr |-> ##2 xferChanDisable == $past(regWrData[17], 2))
    else $error("transfer channel disable decode");
  chk_parity_sync: assert property (modeWr |-> ##2 parityEnable == !$past(regWrData[11], 2) &&
    multiDrop == &$past(regWrData[11:10], 2) && syncMode == $past(regWrData[8], 2))
    else $error("parity or framing decode");
  chk_stop_len: assert property (modeWr |-> ##2
    stopHalfBits == halfOf($past(regWrData[13:12], 2), $past(regWrData[8], 2)))
    else $error("stop length decode");
  chk_clk_drive: assert property (modeWr |-> ##2
    sclkPinOe == ($past(regWrData[18], 2) && !$past(regWrData[5], 2)))
    else $error("clock pin enable decode");
  chk_local_idle: assert property (modeWr && regWrData[15:14] == 2'h2 |-> ##2 txdPin)
    else $error("transmit pin not idle in local loop");
  chk_remote_off: assert property (modeWr && regWrData[15:14] == 2'h3 |-> ##2 !rxPathEnable)
    else $error("receiver active in remote loop");
  chk_tx_remote: assert property (modeWr && regWrData[15:14] == 2'h3 |-> ##2 !txPathEnable)
    else $error("transmitter active in remote loop");
  chk_paths_on: assert property (modeWr && regWrData[15:14] != 2'h3 |-> ##2 rxPathEnable && txPathEnable)
    else $error("path disabled outside remote loop");
  chk_par_kind: assert property (modeWr |-> ##2 parityKind == $past(regWrData[10:9], 2))
    else $error("parity kind decode");
  cov_irq: cover property ($rose(irqOut));
  cov_echo: cover property (modeWr && regWrData[15:14] == 2'h1);
  cov_status: cover property (regRdStrobe && regAddr == 8'h14 ##1 regRdData != 32'h0);
endmodule // usmim_top_asserts
bind usmim_top usmim_top_asserts u_chk (.clk, .reset_n, .regAddr, .regWrData, .regWrStrobe,
  .regRdStrobe, .regRdData, .irqOut, .txdPin, .rxPathEnable, .txPathEnable, .sclkPinOe, .charBits, .syncMode,
  .parityEnable, .parityKind, .multiDrop, .stopHalfBits, .xferChanDisable);
`default_nettype wire

//--- logic/usmim_defines.vh
`ifndef USMIM_DEFINES_VH
`define USMIM_DEFINES_VH

// Register offsets (byte addresses)
`define USMIM_ADDR_W 8
`define USMIM_OFF_MODE 8'h04
`define USMIM_OFF_IRQ_SET 8'h08
`define USMIM_OFF_IRQ_CLR 8'h0C
`define USMIM_OFF_IRQ_MASK 8'h10
`define USMIM_OFF_STATUS 8'h14

// Reset values
`define USMIM_MODE_RST 32'h00000000
`define USMIM_MASK_RST 10'h000
`define USMIM_STATUS_RST 10'h000
`define USMIM_RDATA_RST 32'h00000000

// Writable bits of the mode register
`define USMIM_MODE_WMASK 32'h0006FFF0

// Mode register field positions
`define USMIM_SRC_HI 5
`define USMIM_SRC_LO 4
`define USMIM_CHAR_LENGTH_FIELD_HI 7
`define USMIM_CHAR_LENGTH_FIELD_LO 6
`define USMIM_SYNC_BIT 8
`define USMIM_PAR_HI 11
`define USMIM_PAR_LO 9
`define USMIM_STOP_HI 13
`define USMIM_STOP_LO 12
`define USMIM_CHANNEL_TEST_MODE_HI 15
`define USMIM_CHANNEL_TEST_MODE_LO 14
`define USMIM_NINE_BIT 17
`define USMIM_CLOCK_PIN_DRIVE_BIT 18

// Interrupt source count and positions
`define USMIM_NSRC 10
`define USMIM_IRQ_RECEIVE_READY_FLAG 0
`define USMIM_IRQ_TRANSMIT_READY_FLAG 1
`define USMIM_IRQ_BREAK 2
`define USMIM_IRQ_RXEND 3
`define USMIM_IRQ_TXEND 4
`define USMIM_IRQ_OVRUN 5
`define USMIM_IRQ_FRAME 6
`define USMIM_IRQ_PARITY 7
`define USMIM_IRQ_TMOUT 8
`define USMIM_IRQ_TXIDLE 9

// Field encodings
`define USMIM_SRC_MCK 2'h0
`define USMIM_SRC_MCK8 2'h1
`define USMIM_CHM_NORMAL 2'h0
`define USMIM_CHM_ECHO 2'h1
`define USMIM_CHM_LOCAL 2'h2
`define USMIM_CHM_REMOTE 2'h3
`define USMIM_STOP_ONE 2'h0
`define USMIM_STOP_ONEHALF 2'h1
`define USMIM_STOP_TWO 2'h2
`define USMIM_HALF_ONE 3'h2
`define USMIM_HALF_ONEHALF 3'h3
`define USMIM_HALF_TWO 3'h4
`define USMIM_CHAR_BASE 4'h5
`define USMIM_CHAR_NINE 4'h9

// Master clock divided by eight
`define USMIM_DIV8_W 3
`define USMIM_DIV8_LAST 3'h7
`define USMIM_DIV8_ZERO 3'h0

`endif

//--- logic/usmim_top.v
`include "usmim_defines.vh"
`timescale 1ns/1ns
`default_nettype none

module usmim_top
(
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Register port
  input wire [7:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWrStrobe,
  input wire regRdStrobe,
  output reg [31:0] regRdData,
  // Status events from receiver, transmitter and transfer channels
  input wire [9:0] statusEvent,
  // Interrupt
  output reg irqOut,
  // Serial pins
  input wire rxdPin,
  output reg txdPin,
  input wire sclkPinIn,
  output reg sclkPinOut,
  output reg sclkPinOe,
  // Transmitter and receiver side
  input wire txSerialOut,
  output reg rxSerialIn,
  output reg rxPathEnable,
  output reg txPathEnable,
  // Decoded configuration
  output reg baudTick,
  output reg [3:0] charBits,
  output reg syncMode,
  output reg parityEnable,
  output reg [1:0] parityKind,
  output reg multiDrop,
  output reg [2:0] stopHalfBits,
  output reg xferChanDisable
);

  ////////////////////////////////////////////////////////////////////////
  // Reset release

  reg rstSync1_reg;
  reg rstSync2_reg;
  wire resetN;

  // Two stages so release never lands near a clock edge
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rstSync1_reg <= 1'b0;
      rstSync2_reg <= 1'b0;
    end
    else
    begin
      rstSync1_reg <= 1'b1;
      rstSync2_reg <= rstSync1_reg;
    end
  end

  assign resetN = rstSync2_reg;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  reg rxdS1_reg;
  reg rxdS2_reg;
  reg rxdS3_reg;
  reg rxdLevel_reg;
  reg sclkS1_reg;
  reg sclkS2_reg;
  reg sclkS3_reg;
  reg sclkLevel_reg;
  reg sclkRise;

  // Three stages; the level moves only once stages two and three agree
  always @(posedge clk or negedge resetN)
  begin
    if (!resetN)
    begin
      rxdS1_reg <= 1'b1;
      rxdS2_reg <= 1'b1;
      rxdS3_reg <= 1'b1;
      rxdLevel_reg <= 1'b1;
      sclkS1_reg <= 1'b0;
      sclkS2_reg <= 1'b0;
      sclkS3_reg <= 1'b0;
      sclkLevel_reg <= 1'b0;
    end
    else
    begin
      rxdS1_reg <= rxdPin;
      rxdS2_reg <= rxdS1_reg;
      rxdS3_reg <= rxdS2_reg;
      if (rxdS2_reg == rxdS3_reg)
      begin
        rxdLevel_reg <= rxdS3_reg;
      end
      sclkS1_reg <= sclkPinIn;
      sclkS2_reg <= sclkS1_reg;
      sclkS3_reg <= sclkS2_reg;
      if (sclkS2_reg == sclkS3_reg)
      begin
        sclkLevel_reg <= sclkS3_reg;
      end
    end
  end

  // Rising edge of the filtered external clock
  always @*
  begin
    sclkRise = (sclkS2_reg == sclkS3_reg) && sclkS3_reg && !sclkLevel_reg;
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file

  reg [31:0] mode_reg;
  reg [9:0] mask_reg;
  reg [9:0] status_reg;
  reg [9:0] mask_next;
  reg [9:0] status_next;
  reg [31:0] rdData_next;
  reg statusRead;

  // Mode register fields
  wire [1:0] srcSel = mode_reg[`USMIM_SRC_HI:`USMIM_SRC_LO];
  wire [1:0] chrlSel = mode_reg[`USMIM_CHAR_LENGTH_FIELD_HI:`USMIM_CHAR_LENGTH_FIELD_LO];
  wire syncSel = mode_reg[`USMIM_SYNC_BIT];
  wire [2:0] parSel = mode_reg[`USMIM_PAR_HI:`USMIM_PAR_LO];
  wire [1:0] stopSel = mode_reg[`USMIM_STOP_HI:`USMIM_STOP_LO];
  wire [1:0] chmodeSel = mode_reg[`USMIM_CHANNEL_TEST_MODE_HI:`USMIM_CHANNEL_TEST_MODE_LO];
  wire nineSel = mode_reg[`USMIM_NINE_BIT];
  wire clkoSel = mode_reg[`USMIM_CLOCK_PIN_DRIVE_BIT];

  // Mask and status updates
  always @*
  begin
    statusRead = regRdStrobe && (regAddr == `USMIM_OFF_STATUS);
    mask_next = mask_reg;
    if (regWrStrobe && (regAddr == `USMIM_OFF_IRQ_SET))
    begin
      mask_next = mask_reg | regWrData[`USMIM_NSRC-1:0];
    end
    if (regWrStrobe && (regAddr == `USMIM_OFF_IRQ_CLR))
    begin
      mask_next = mask_reg & ~regWrData[`USMIM_NSRC-1:0];
    end
    // Set beats clear so an event during the read is kept
    status_next = (statusRead ? `USMIM_STATUS_RST : status_reg) | statusEvent;
  end

  // Read mux; unmapped and write-only offsets read zero
  always @*
  begin
    rdData_next = `USMIM_RDATA_RST;
    case (regAddr)
      `USMIM_OFF_MODE: rdData_next = mode_reg;
      `USMIM_OFF_IRQ_MASK: rdData_next = {22'h000000, mask_reg};
      `USMIM_OFF_STATUS: rdData_next = {22'h000000, status_reg};
      default: rdData_next = `USMIM_RDATA_RST;
    endcase
  end

  // Register storage, read data and interrupt line
  always @(posedge clk or negedge resetN)
  begin
    if (!resetN)
    begin
      mode_reg <= `USMIM_MODE_RST;
      mask_reg <= `USMIM_MASK_RST;
      status_reg <= `USMIM_STATUS_RST;
      regRdData <= `USMIM_RDATA_RST;
      irqOut <= 1'b0;
    end
    else
    begin
      if (regWrStrobe && (regAddr == `USMIM_OFF_MODE))
      begin
        mode_reg <= regWrData & `USMIM_MODE_WMASK;
      end
      mask_reg <= mask_next;
      status_reg <= status_next;
      if (regRdStrobe)
      begin
        regRdData <= rdData_next;
      end
      else
      begin
        regRdData <= `USMIM_RDATA_RST;
      end
      // Built from next values so the flop tracks the registers exactly
      irqOut <= |(status_next & mask_next);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Baud generator clock source

  reg [2:0] div8_reg;
  reg sclkToggle_reg;
  reg tick_next;

  // Pick the tick that feeds the baud generator
  always @*
  begin
    case (srcSel)
      `USMIM_SRC_MCK: tick_next = 1'b1;
      `USMIM_SRC_MCK8: tick_next = (div8_reg == `USMIM_DIV8_LAST);
      default: tick_next = sclkRise;
    endcase
  end

  // Divider runs free; a source change may shorten the first period
  always @(posedge clk or negedge resetN)
  begin
    if (!resetN)
    begin
      div8_reg <= `USMIM_DIV8_ZERO;
      baudTick <= 1'b0;
      sclkToggle_reg <= 1'b0;
      sclkPinOut <= 1'b0;
      sclkPinOe <= 1'b0;
    end
    else
    begin
      div8_reg <= div8_reg + 3'h1;
      baudTick <= tick_next;
      if (tick_next)
      begin
        sclkToggle_reg <= !sclkToggle_reg;
      end
      // Never drive the pin while it is our own clock input
      sclkPinOe <= clkoSel && !srcSel[1];
      sclkPinOut <= (clkoSel && !srcSel[1]) ? sclkToggle_reg : 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Channel routing

  reg txd_next;
  reg rxIn_next;
  reg rxEn_next;
  reg txEn_next;

  // Test modes steer pins and enables
  always @*
  begin
    txd_next = txSerialOut;
    rxIn_next = rxdLevel_reg;
    rxEn_next = 1'b1;
    txEn_next = 1'b1;
    case (chmodeSel)
      `USMIM_CHM_NORMAL:
      begin
        txd_next = txSerialOut;
        rxIn_next = rxdLevel_reg;
      end
      `USMIM_CHM_ECHO:
      begin
        txd_next = rxdLevel_reg;
        rxIn_next = rxdLevel_reg;
      end
      `USMIM_CHM_LOCAL:
      begin
        txd_next = 1'b1;
        rxIn_next = txSerialOut;
      end
      default:
      begin
        txd_next = rxdLevel_reg;
        rxIn_next = 1'b1;
        rxEn_next = 1'b0;
        txEn_next = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Decoded framing

  reg [3:0] charBits_next;
  reg [2:0] stop_next;

  // Character length and stop bits
  always @*
  begin
    if (nineSel)
    begin
      charBits_next = `USMIM_CHAR_NINE;
    end
    else
    begin
      charBits_next = `USMIM_CHAR_BASE + {2'h0, chrlSel};
    end
    case (stopSel)
      `USMIM_STOP_ONE: stop_next = `USMIM_HALF_ONE;
      `USMIM_STOP_TWO: stop_next = `USMIM_HALF_TWO;
      // One and a half exists only without a bit clock
      `USMIM_STOP_ONEHALF: stop_next = syncSel ? `USMIM_HALF_ONE : `USMIM_HALF_ONEHALF;
      default: stop_next = `USMIM_HALF_ONE;
    endcase
  end

  // Output flops for routing and framing
  always @(posedge clk or negedge resetN)
  begin
    if (!resetN)
    begin
      txdPin <= 1'b1;
      rxSerialIn <= 1'b1;
      rxPathEnable <= 1'b1;
      txPathEnable <= 1'b1;
      charBits <= `USMIM_CHAR_BASE;
      syncMode <= 1'b0;
      parityEnable <= 1'b1;
      parityKind <= 2'h0;
      multiDrop <= 1'b0;
      stopHalfBits <= `USMIM_HALF_ONE;
      xferChanDisable <= 1'b0;
    end
    else
    begin
      txdPin <= txd_next;
      rxSerialIn <= rxIn_next;
      rxPathEnable <= rxEn_next;
      txPathEnable <= txEn_next;
      charBits <= charBits_next;
      syncMode <= syncSel;
      parityEnable <= !parSel[2];
      parityKind <= parSel[1:0];
      multiDrop <= parSel[2] && parSel[1];
      stopHalfBits <= stop_next;
      xferChanDisable <= nineSel;
    end
  end

endmodule // usmim_top

`default_nettype wire
